// file: test/chd_link_assertions.sv
// Purpose: watch the byte link between host end and command decoder
// Assumes: one clock MCLK, synchronous active-high RESET
// Notes: helper logic tracks the command byte and read count per frame
`timescale 1ns/1ps
module chd_link_assertions
   import chd_pkg::*;
(
   input wire logic MCLK, // system clock
   input wire logic RESET, // sync reset
   input wire logic cs_n, // frame select
   input wire logic wr_valid, // host byte strobe
   input wire logic [7:0] wr_byte, // host byte
   input wire logic rd_req, // read request
   input wire logic rd_valid, // device read strobe
   input wire logic [7:0] rd_byte // device read byte
);
   logic got_cmd;
   logic [7:0] cmd;
   logic [4:0] rcnt;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);
   // frame tracking, cleared whenever the frame is closed
   always_ff @(posedge MCLK) begin
      if (RESET || cs_n) begin
         got_cmd <= 1'b0;
         rcnt <= 5'h00;
         cmd <= 8'h00;
      end else begin
         if (wr_valid && !got_cmd) begin
            got_cmd <= 1'b1;
            cmd <= wr_byte;
         end
         if (rd_valid) rcnt <= rcnt + 5'h01;
      end
   end
   a_rd_has_cause: assert property (
      rd_valid |-> $past(rd_req) && !$past(cs_n))
      else $error("read strobe without request");
   a_id_first: assert property (
      rd_valid && rcnt == 5'h00 |-> rd_byte == ID_CODE)
      else $error("first read byte not id");
   a_no_rd_write: assert property (
      rd_valid |-> got_cmd && !cmd[CMD_RW_BIT])
      else $error("read data in write frame");
   a_forbid_silent: assert property (
      rd_valid |-> cmd[TYPE_MSB:TYPE_LSB] != TYPE_FORBID)
      else $error("forbidden type answered");
   a_reg_len: assert property (
      rd_valid && cmd[TYPE_MSB:TYPE_LSB] != TYPE_RAM |->
      rcnt <= {3'h0, cmd[1:0]} + 5'h01)
      else $error("register overrun");
   a_ram_len: assert property (
      rd_valid && cmd[TYPE_MSB:TYPE_LSB] == TYPE_RAM |->
      rcnt <= 5'h10 && cmd[4:0] < NUM_BLOCKS)
      else $error("ram overrun");
   a_ram_lowbits: assert property (
      rd_valid && cmd[TYPE_MSB:TYPE_LSB] == TYPE_RAM &&
      rcnt != 5'h00 && !rcnt[0] |-> rd_byte[1:0] == 2'h0)
      else $error("ram low bits set");
   a_rd_hold: assert property (!rd_valid |-> $stable(rd_byte))
      else $error("read byte moved");
   a_wr_in_frame: assert property (wr_valid |-> !cs_n)
      else $error("write strobe outside frame");
   a_rd_req_frame: assert property (rd_req |-> !cs_n)
      else $error("read request outside frame");
   a_idle_quiet: assert property (
      cs_n && $past(cs_n) |-> !rd_valid)
      else $error("read strobe while idle");
endmodule

// file: test/codec_host_command_decoder_tb.sv
// Purpose: host end and decoder joined, plus a second decoder for misuse
// Assumes: user port steps spaced by an idle edge
// Notes: expected bytes derive from the written patterns only
`timescale 1ns/1ps
module codec_host_command_decoder_tb;
   import chd_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic cv = 1'b0, wv = 1'b0, rq = 1'b0, ue = 1'b0, hit2 = 1'b0;
   logic [7:0] cmd = 8'h00, wd = 8'h00, rdd;
   logic [1:0] chan = 2'h0;
   logic [5:0] caddr = 6'h00;
   logic rdy, rv, idok, refd;
   logic [13:0] cdata;
   logic [3:0] ce, ce2;
   int fails = 0, checks_done = 0, cyc = 0;
   chd_link_if lk();
   chd_link_if lk2();
   chd_device u_chd_device(.MCLK(mclk), .RESET(rst), .link(lk),
      .COEF_CHAN(chan), .COEF_ADDR(caddr), .COEF_DATA(cdata),
      .CHAN_ENABLE(ce));
   chd_host u_chd_host(.MCLK(mclk), .RESET(rst), .link(lk),
      .USER_CMD_VALID(cv), .USER_CMD(cmd), .USER_WR_VALID(wv),
      .USER_WR_DATA(wd), .USER_RD_REQ(rq), .USER_END(ue),
      .USER_READY(rdy), .USER_RD_VALID(rv), .USER_RD_DATA(rdd),
      .USER_ID_OK(idok), .USER_REFUSED(refd));
   // second decoder is driven straight by the bench to break the rules
   chd_device u_chd_device_2(.MCLK(mclk), .RESET(rst), .link(lk2),
      .COEF_CHAN(2'h0), .COEF_ADDR(6'h00), .COEF_DATA(),
      .CHAN_ENABLE(ce2));
   chd_link_assertions u_chd_link_assertions(.MCLK(mclk), .RESET(rst),
      .cs_n(lk.cs_n), .wr_valid(lk.wr_valid), .wr_byte(lk.wr_byte),
      .rd_req(lk.rd_req), .rd_valid(lk.rd_valid), .rd_byte(lk.rd_byte));
   initial begin
      lk2.cs_n = 1'b1;
      lk2.wr_valid = 1'b0;
      lk2.wr_byte = 8'h00;
      lk2.rd_req = 1'b0;
   end
   // clock and watchdog; the sticky flag catches any second-link answer
   initial begin
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (lk2.rd_valid === 1'b1) hit2 <= 1'b1;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task cmd_go(input logic [7:0] c);
      int i;
      for (i = 0; i < 20 && rdy !== 1'b1; i++) @(posedge mclk);
      @(posedge mclk) begin cv <= 1'b1; cmd <= c; end
      @(posedge mclk) cv <= 1'b0;
   endtask
   task wrb(input logic [7:0] d);
      @(posedge mclk) begin wv <= 1'b1; wd <= d; end
      @(posedge mclk) wv <= 1'b0;
   endtask
   task fin;
      @(posedge mclk) ue <= 1'b1;
      @(posedge mclk) ue <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
   task rdb(input string nm, input logic [7:0] e);
      int i;
      @(posedge mclk) rq <= 1'b1;
      @(posedge mclk) rq <= 1'b0;
      for (i = 0; i < 8; i++) begin
         @(posedge mclk);
         #1;
         if (rv === 1'b1) break;
      end
      chk({nm, "_strobe"}, 16'h0001, {15'h0, rv});
      chk(nm, {8'h00, e}, {8'h00, rdd});
   endtask
   task rid; // the first read fetches the identification byte
      @(posedge mclk) rq <= 1'b1;
      @(posedge mclk) rq <= 1'b0;
      repeat (4) @(posedge mclk);
      #1 chk("id_ok", 16'h0001, {15'h0, idok});
   endtask
   task wseq(input logic [7:0] c, input int n, input logic [31:0] d);
      int i;
      cmd_go(c);
      for (i = 0; i < n; i++) wrb(d[31-8*i -: 8]);
      fin();
   endtask
   task rseq(input logic [7:0] c, input int n, input logic [31:0] e);
      int i;
      cmd_go(c);
      rid();
      for (i = 0; i < n; i++) rdb("reg_byte", e[31-8*i -: 8]);
      fin();
   endtask
   task ena(input logic [7:0] d, input logic [3:0] e);
      wseq(8'hA5, 1, {d, 24'h0});
      chk("chan_enable", {12'h0, e}, {12'h0, ce});
   endtask
   // n whole words from word 7 down, then optionally a lone high byte
   task ramw(input logic [7:0] c, input logic [1:0] k, input int n,
      input bit hi);
      int i;
      cmd_go(c);
      for (i = 0; i < n; i++) begin
         wrb({k, 6'(7 - i)});
         wrb(8'h0F);
      end
      if (hi) wrb({k, 6'(7 - n)});
      fin();
   endtask
   task coef(input logic [1:0] ch, input logic [5:0] a, input logic [1:0] k);
      @(posedge mclk) begin chan <= ch; caddr <= a; end
      repeat (2) @(posedge mclk);
      #1 chk("coef", {2'h0, k, 6'(a % 8), 6'h03}, {2'h0, cdata});
   endtask
   task t_regs;
      ena(8'hF0, 4'hF);
      wseq(8'h83, 4, 32'h11223344);
      ena(8'h20, 4'h2);
      rseq(8'h03, 4, 32'h11223344);
      ena(8'h10, 4'h1);
      wseq(8'h81, 2, 32'h55660000);
      rseq(8'h01, 2, 32'h55660000);
      ena(8'h20, 4'h2);
      rseq(8'h01, 2, 32'h33440000);
   endtask
   task t_abort;
      ena(8'h10, 4'h1);
      wseq(8'h82, 1, 32'h77000000);
      rseq(8'h02, 3, 32'h77556600);
   endtask
   task t_global; // second byte after a single-byte address is dropped
      ena(8'h00, 4'h0);
      wseq(8'hA0, 2, 32'hC33C0000);
      rseq(8'h21, 2, 32'h00C30000);
   endtask
   task t_refuse;
      int i;
      logic seen;
      seen = 1'b0;
      cmd_go(8'h00);
      // refusal pulse stands one cycle only, so look before the next edge
      for (i = 0; i < 4 && seen !== 1'b1; i++) begin
         #1 seen = refd;
         @(posedge mclk);
      end
      #1 chk("refused", 16'h0001, {15'h0, seen});
      chk("no_frame", 16'h0001, {15'h0, lk.cs_n});
      chk("ready_idle", 16'h0001, {15'h0, rdy});
   endtask
   task t_ram;
      int i;
      ena(8'h10, 4'h1);
      ramw(8'hE0, 2'h1, 8, 1'b0);
      for (i = 0; i < 8; i++) coef(2'h0, 6'(i), 2'h1);
      cmd_go(8'h60);
      rid();
      for (i = 0; i < 8; i++) begin
         rdb("ram_hi", {2'h1, 6'(7 - i)});
         rdb("ram_lo", 8'h0C);
      end
      fin();
      ramw(8'hE0, 2'h2, 2, 1'b1);
      coef(2'h0, 6'h06, 2'h2);
      coef(2'h0, 6'h05, 2'h1);
      ramw(8'hE4, 2'h3, 8, 1'b0);
      coef(2'h3, 6'h27, 2'h3);
      coef(2'h1, 6'h20, 2'h3);
      ena(8'h20, 4'h2);
      ramw(8'hE2, 2'h2, 4, 1'b0);
      ena(8'h10, 4'h1);
      ramw(8'hE2, 2'h3, 4, 1'b0);
      coef(2'h1, 6'h17, 2'h2);
      coef(2'h0, 6'h14, 2'h3);
   endtask
   task l2(input logic [7:0] b);
      @(posedge mclk) begin
         lk2.cs_n <= 1'b0;
         lk2.wr_valid <= 1'b1;
         lk2.wr_byte <= b;
      end
      @(posedge mclk) lk2.wr_valid <= 1'b0;
   endtask
   task l2_close;
      @(posedge mclk) lk2.cs_n <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask
   task t_forbid;
      l2(8'hC5);
      l2(8'hF0);
      l2_close();
      chk("forbid_wr", 16'h0000, {12'h0, ce2});
      l2(8'h40);
      @(posedge mclk) lk2.rd_req <= 1'b1;
      @(posedge mclk) lk2.rd_req <= 1'b0;
      l2_close();
      chk("forbid_rd", 16'h0000, {15'h0, hit2});
      l2(8'hA5);
      l2(8'hF0);
      l2_close();
      chk("legal_wr", 16'h000F, {12'h0, ce2});
      // forbidden read through the host end, watched by the checker too
      cmd_go(8'h40);
      @(posedge mclk) rq <= 1'b1;
      @(posedge mclk) rq <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 chk("forbid_host", 16'h0000, {15'h0, rv});
      fin();
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // main sequence after ten reset cycles
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_regs();
      t_abort();
      t_global();
      t_refuse();
      t_ram();
      t_forbid();
      stop_test();
   end
endmodule

// file: verilog/chd_device.sv
// Purpose: command decoder of a four-channel codec control port
// Assumes: host end keeps its own obligations (single channel on reads)
// Notes: register and coefficient contents are plain storage here
`timescale 1ns/1ps
module chd_device (
   input wire logic MCLK,                       // system clock
   input wire logic RESET,                      // sync reset, active high
   chd_link_if.device link,                     // host facing link
   input wire logic [1:0] COEF_CHAN,            // datapath channel select
   input wire logic [5:0] COEF_ADDR,            // datapath word index
   output logic [chd_pkg::COEF_W-1:0] COEF_DATA, // datapath coefficient
   output logic [3:0] CHAN_ENABLE               // channel enable bits
);
   import chd_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WRITE = 3'b001,
      ST_READ_ID = 3'b010,
      ST_READ = 3'b011,
      ST_DONE = 3'b100
   } chd_state_t;

   chd_state_t state;
   logic [1:0] kind;          // command type of current frame
   logic [4:0] reg_addr;      // current register address
   logic [2:0] blk;           // current coefficient block
   logic [2:0] cnt;           // items left after current one
   logic half;                // 1 once the high byte has passed
   logic [7:0] hi_byte;       // held high byte of a coefficient write
   logic [3:0] ce;
   logic [7:0] loc_reg [NUM_CH][32];
   logic [7:0] glob_reg [32];
   logic [COEF_W-1:0] coef [RAM_WORDS];
   logic [COEF_W-1:0] tone [NUM_CH][TONE_WORDS];

   // lowest enabled channel, used for reads
   function automatic logic [1:0] first_ch(input logic [3:0] en);
      logic [1:0] r;
      r = 2'h0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (en[i]) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction

   // tone words are the upper half of the tone block
   function automatic logic is_tone(input logic [2:0] b,
                                    input logic [2:0] w);
      return (b == TONE_BLOCK) && w[2];
   endfunction

   logic wr_fire;
   logic rd_fire;
   logic [5:0] word_idx;
   logic last_item;
   logic [COEF_W-1:0] cur_word;
   logic [15:0] cur_word16;
   logic [1:0] rd_ch;
   logic [1:0] cmd_type;

   assign cmd_type = link.wr_byte[TYPE_MSB:TYPE_LSB];
   assign wr_fire = (state == ST_WRITE) && link.wr_valid;
   assign rd_fire = (state == ST_READ) && link.rd_req;
   assign word_idx = 6'({blk, cnt});
   assign rd_ch = first_ch(ce);
   assign cur_word = is_tone(blk, cnt) ? tone[rd_ch][cnt[1:0]]
                                       : coef[word_idx];
   assign cur_word16 = {cur_word, 2'b00};
   // a coefficient item ends on its low byte, a register on every byte
   assign last_item = (cnt == 3'h0) && ((kind != TYPE_RAM) || half);
   assign CHAN_ENABLE = ce;

   // frame sequencer; a released frame drops whatever is left
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         state <= ST_IDLE;
         kind <= TYPE_LOCAL;
         reg_addr <= 5'h00;
         blk <= 3'h0;
         cnt <= 3'h0;
         half <= 1'b0;
      end else if (link.cs_n) begin
         state <= ST_IDLE;
         half <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (link.wr_valid) begin
                  kind <= cmd_type;
                  reg_addr <= link.wr_byte[ADDR_W-1:0];
                  blk <= link.wr_byte[2:0];
                  half <= 1'b0;
                  // ram walks all words, registers addr[1:0]+1 bytes
                  cnt <= (cmd_type == TYPE_RAM) ? 3'(BLOCK_WORDS - 1)
                         : {1'b0, link.wr_byte[1:0]};
                  if (cmd_type == TYPE_FORBID ||
                      (cmd_type == TYPE_RAM &&
                       link.wr_byte[ADDR_W-1:0] >= 5'(NUM_BLOCKS))) begin
                     state <= ST_DONE;
                  end else if (link.wr_byte[CMD_RW_BIT]) begin
                     state <= ST_WRITE;
                  end else begin
                     state <= ST_READ_ID;
                  end
               end
            end
            ST_WRITE, ST_READ: begin
               if (wr_fire || rd_fire) begin
                  if (last_item) begin
                     state <= ST_DONE;
                  end else if (kind == TYPE_RAM) begin
                     half <= ~half;
                     if (half) begin
                        cnt <= cnt - 3'h1;
                     end
                  end else begin
                     cnt <= cnt - 3'h1;
                     reg_addr <= reg_addr - 5'h01;
                  end
               end
            end
            ST_READ_ID: begin
               if (link.rd_req) begin
                  state <= ST_READ;
               end
            end
            ST_DONE: begin
               state <= ST_DONE;          // extra bytes ignored until release
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // register stores; only completed bytes land, so an abort keeps them
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ce <= CE_RESET;
         for (int r = 0; r < 32; r++) begin
            glob_reg[r] <= REG_RESET;
            for (int c = 0; c < NUM_CH; c++) begin
               loc_reg[c][r] <= REG_RESET;
            end
         end
      end else if (wr_fire && kind == TYPE_GLOBAL) begin
         glob_reg[reg_addr] <= link.wr_byte;
         if (reg_addr == CE_ADDR) begin
            ce <= link.wr_byte[CE_LSB +: NUM_CH];
         end
      end else if (wr_fire && kind == TYPE_LOCAL) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (ce[c]) begin
               loc_reg[c][reg_addr] <= link.wr_byte;
            end
         end
      end
   end

   // coefficient stores; a word is written only when its low byte arrives
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         hi_byte <= 8'h00;
      end else if (wr_fire && kind == TYPE_RAM) begin
         if (!half) begin
            hi_byte <= link.wr_byte;
         end else if (is_tone(blk, cnt)) begin
            for (int c = 0; c < NUM_CH; c++) begin
               if (ce[c]) begin
                  tone[c][cnt[1:0]] <= {hi_byte, link.wr_byte[7:2]};
               end
            end
         end else begin
            coef[word_idx] <= {hi_byte, link.wr_byte[7:2]};
         end
      end
   end

   // read data one cycle after each request made in ST_READ_ID or ST_READ
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         link.rd_valid <= 1'b0;
         link.rd_byte <= 8'h00;
      end else begin
         link.rd_valid <= 1'b0;
         if (!link.cs_n && state == ST_READ_ID && link.rd_req) begin
            link.rd_valid <= 1'b1;
            link.rd_byte <= ID_CODE;
         end else if (!link.cs_n && rd_fire) begin
            link.rd_valid <= 1'b1;
            case (kind)
               TYPE_GLOBAL: link.rd_byte <= glob_reg[reg_addr];
               TYPE_LOCAL: link.rd_byte <= loc_reg[rd_ch][reg_addr];
               TYPE_RAM: link.rd_byte <= half ? cur_word16[7:0]
                                              : cur_word16[15:8];
               default: link.rd_byte <= 8'h00;
            endcase
         end
      end
   end

   // datapath view of coefficients; out of range reads zero
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         COEF_DATA <= '0;
      end else if (COEF_ADDR >= 6'(RAM_WORDS)) begin
         COEF_DATA <= '0;
      end else if (is_tone(COEF_ADDR[5:3], COEF_ADDR[2:0])) begin
         COEF_DATA <= tone[COEF_CHAN][COEF_ADDR[1:0]];
      end else begin
         COEF_DATA <= coef[COEF_ADDR];
      end
   end
endmodule

// file: verilog/chd_host.sv
// Purpose: host end driving the codec command decoder link
// Assumes: user logic on MCLK issues one step at a time
// Notes: refuses channel reads unless exactly one channel is enabled
`timescale 1ns/1ps
module chd_host (
   input wire logic MCLK,            // system clock
   input wire logic RESET,           // sync reset, active high
   chd_link_if.host link,            // device facing link
   input wire logic USER_CMD_VALID,  // open frame with command byte
   input wire logic [7:0] USER_CMD,  // command byte
   input wire logic USER_WR_VALID,   // send data byte in frame
   input wire logic [7:0] USER_WR_DATA, // data byte
   input wire logic USER_RD_REQ,     // fetch next read byte
   input wire logic USER_END,        // close frame
   output logic USER_READY,          // ready for a new command
   output logic USER_RD_VALID,       // read data strobe
   output logic [7:0] USER_RD_DATA,  // read data
   output logic USER_ID_OK,          // last identification byte matched
   output logic USER_REFUSED         // command refused, one cycle
);
   import chd_pkg::*;

   typedef enum logic {
      HS_IDLE = 1'b0,
      HS_FRAME = 1'b1
   } chd_hstate_t;

   chd_hstate_t state;
   logic [3:0] ce_shadow;     // enables as last written by this host
   logic ce_pending;          // next data byte goes to the enable register
   logic id_pending;          // next read byte is the identification
   logic chan_read;

   assign USER_READY = (state == HS_IDLE);
   // local reads and tone-block reads need a single enabled channel
   assign chan_read = !USER_CMD[CMD_RW_BIT] &&
      (USER_CMD[TYPE_MSB:TYPE_LSB] == TYPE_LOCAL ||
       (USER_CMD[TYPE_MSB:TYPE_LSB] == TYPE_RAM &&
        USER_CMD[2:0] == TONE_BLOCK));

   // frame and strobe generation
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         state <= HS_IDLE;
         link.cs_n <= 1'b1;
         link.wr_valid <= 1'b0;
         link.wr_byte <= 8'h00;
         link.rd_req <= 1'b0;
         USER_REFUSED <= 1'b0;
         id_pending <= 1'b0;
         ce_pending <= 1'b0;
      end else begin
         link.wr_valid <= 1'b0;
         link.rd_req <= 1'b0;
         USER_REFUSED <= 1'b0;
         case (state)
            HS_IDLE: begin
               if (USER_CMD_VALID && chan_read &&
                   !$onehot(ce_shadow)) begin
                  USER_REFUSED <= 1'b1;
               end else if (USER_CMD_VALID) begin
                  state <= HS_FRAME;
                  link.cs_n <= 1'b0;
                  link.wr_valid <= 1'b1;
                  link.wr_byte <= USER_CMD;
                  id_pending <= !USER_CMD[CMD_RW_BIT];
                  ce_pending <= (USER_CMD == {1'b1, TYPE_GLOBAL, CE_ADDR});
               end
            end
            HS_FRAME: begin
               if (USER_END) begin
                  state <= HS_IDLE;
                  link.cs_n <= 1'b1;
                  ce_pending <= 1'b0;
               end else if (USER_WR_VALID) begin
                  link.wr_valid <= 1'b1;
                  link.wr_byte <= USER_WR_DATA;
                  ce_pending <= 1'b0;
               end else if (USER_RD_REQ) begin
                  link.rd_req <= 1'b1;
               end
               if (link.rd_valid) begin
                  id_pending <= 1'b0;
               end
            end
            default: begin
               state <= HS_IDLE;
            end
         endcase
      end
   end

   // shadow of the enable register for the read check
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ce_shadow <= CE_RESET;
      end else if (state == HS_FRAME && !USER_END && USER_WR_VALID &&
                   ce_pending) begin
         ce_shadow <= USER_WR_DATA[CE_LSB +: NUM_CH];
      end
   end

   // identification byte is checked, data bytes are passed on
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         USER_RD_VALID <= 1'b0;
         USER_RD_DATA <= 8'h00;
         USER_ID_OK <= 1'b0;
      end else begin
         USER_RD_VALID <= 1'b0;
         if (link.rd_valid && id_pending) begin
            USER_ID_OK <= (link.rd_byte == ID_CODE);
         end else if (link.rd_valid) begin
            USER_RD_VALID <= 1'b1;
            USER_RD_DATA <= link.rd_byte;
         end
      end
   end
endmodule

// file: verilog/chd_link_if.sv
// Purpose: byte-level link between host end and codec command decoder
// Assumes: both ends on MCLK; serial bit timing lies outside
// Notes: cs_n low frames a transfer; strobes are one-cycle pulses
`timescale 1ns/1ps
interface chd_link_if;
   logic cs_n;          // frame select, active low
   logic wr_valid;      // host byte strobe
   logic [7:0] wr_byte; // host byte
   logic rd_req;        // host asks for next read byte
   logic rd_valid;      // device byte strobe
   logic [7:0] rd_byte; // device byte
   modport device (input cs_n, wr_valid, wr_byte, rd_req,
                   output rd_valid, rd_byte);
   modport host (output cs_n, wr_valid, wr_byte, rd_req,
                 input rd_valid, rd_byte);
endinterface

// file: verilog/chd_pkg.sv
// Purpose: shared constants of the codec host command decoder
// Assumes: one clock MCLK, synchronous active-high RESET
// Notes: identification value below is arbitrary, not a real part code
package chd_pkg;
   localparam int NUM_CH = 4;               // channels
   localparam int CMD_RW_BIT = 7;           // 1 write, 0 read
   localparam int TYPE_MSB = 6;             // command type field msb
   localparam int TYPE_LSB = 5;             // command type field lsb
   localparam int ADDR_W = 5;               // address field width
   localparam logic [1:0] TYPE_LOCAL = 2'h0;
   localparam logic [1:0] TYPE_GLOBAL = 2'h1;
   localparam logic [1:0] TYPE_FORBID = 2'h2;
   localparam logic [1:0] TYPE_RAM = 2'h3;
   localparam logic [4:0] CE_ADDR = 5'h05;  // channel enable global address
   localparam int CE_LSB = 4;               // enable field position in byte
   localparam logic [3:0] CE_RESET = 4'h0;  // reset value of enables
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int COEF_W = 14;              // coefficient word width
   localparam int NUM_BLOCKS = 5;           // coefficient blocks
   localparam int BLOCK_WORDS = 8;          // words per block
   localparam int RAM_WORDS = 40;           // total shared words
   localparam logic [2:0] TONE_BLOCK = 3'h2;   // block holding tone words
   localparam int TONE_WORDS = 4;           // tone words per channel
   localparam logic [7:0] ID_CODE = 8'h5A;  // arbitrary identification value
endpackage
